// ==== logic/hdrl_params.svh ====
// constants of the hub descriptor and bus-reset logic
`ifndef HDRL_PARAMS_SVH
`define HDRL_PARAMS_SVH

// descriptor byte offsets
`define HDRL_OFS_LENGTH     5'h00
`define HDRL_OFS_TYPE       5'h01
`define HDRL_OFS_REL_LO     5'h02
`define HDRL_OFS_REL_HI     5'h03
`define HDRL_OFS_CLASS      5'h04
`define HDRL_OFS_SUBCLASS   5'h05
`define HDRL_OFS_PROTOCOL   5'h06
`define HDRL_OFS_MAXPKT     5'h07
`define HDRL_OFS_VID_LO     5'h08
`define HDRL_OFS_VID_HI     5'h09
`define HDRL_OFS_PID_LO     5'h0a
`define HDRL_OFS_PID_HI     5'h0b
`define HDRL_OFS_DID_LO     5'h0c
`define HDRL_OFS_DID_HI     5'h0d
`define HDRL_OFS_MFG_IDX    5'h0e
`define HDRL_OFS_PROD_IDX   5'h0f
`define HDRL_OFS_SER_IDX    5'h10
`define HDRL_OFS_NUM_CFG    5'h11

// descriptor field values
`define HDRL_DESC_LENGTH    8'h12
`define HDRL_DESC_TYPE_DEV  8'h01
`define HDRL_DESC_RELEASE   16'h0200
`define HDRL_DESC_CLASS_HUB 8'h09
`define HDRL_DESC_SUBCLASS  8'h00
`define HDRL_DESC_PROTOCOL  8'h00
`define HDRL_DESC_MAXPKT0   8'h40
`define HDRL_DESC_NUM_CFG   8'h01
`define HDRL_STR_NONE       8'h00
`define HDRL_STR_MFG        8'h01
`define HDRL_STR_PROD       8'h02
`define HDRL_STR_SER        8'h03

// reset values of hub-level state, and the all-fields-loaded mask
`define HDRL_ADDR_DEFAULT   7'h00
`define HDRL_CFG_NONE       8'h00
`define HDRL_PWR_OFF        3'h0
`define HDRL_ID_DEFAULT     16'h0000
`define HDRL_FLD_ALL        3'h7

`endif

// ==== logic/hdrl_pkg.sv ====
// types shared by the hub descriptor and bus-reset logic
package hdrl_pkg;

	typedef struct packed {
		logic        valid;
		logic [1:0]  sel;
		logic [15:0] value;
	} hdrl_id_load_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  offset;
	} hdrl_desc_req_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  data;
		logic        last;
	} hdrl_desc_rsp_t;

	typedef enum logic [1:0] {
		HDRL_ST_LOADING   = 2'b00,
		HDRL_ST_ATTACHED  = 2'b01,
		HDRL_ST_SUSPENDED = 2'b10
	} hdrl_state_t;

endpackage : hdrl_pkg

// ==== logic/hdrl_desc_rom.sv ====
// device descriptor byte store with registered read data
`timescale 1ns/1ns
`include "hdrl_params.svh"

module hdrl_desc_rom
	import hdrl_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        rd_en_in,
	input  wire logic [4:0]  rd_ofs_in,
	input  wire logic        string_en_in,
	input  wire logic [15:0] vid_in,
	input  wire logic [15:0] pid_in,
	input  wire logic [15:0] did_in,
	output logic      [7:0]  rd_data_out
);

	logic [7:0] byte_sel;

	localparam logic [15:0] DESC_REL = `HDRL_DESC_RELEASE;

	// multi-byte fields go out low byte first
	always_comb begin
		unique case (rd_ofs_in)
			`HDRL_OFS_LENGTH:   byte_sel = `HDRL_DESC_LENGTH;
			`HDRL_OFS_TYPE:     byte_sel = `HDRL_DESC_TYPE_DEV;
			`HDRL_OFS_REL_LO:   byte_sel = DESC_REL[7:0];
			`HDRL_OFS_REL_HI:   byte_sel = DESC_REL[15:8];
			`HDRL_OFS_CLASS:    byte_sel = `HDRL_DESC_CLASS_HUB;
			`HDRL_OFS_SUBCLASS: byte_sel = `HDRL_DESC_SUBCLASS;
			`HDRL_OFS_PROTOCOL: byte_sel = `HDRL_DESC_PROTOCOL;
			`HDRL_OFS_MAXPKT:   byte_sel = `HDRL_DESC_MAXPKT0;
			`HDRL_OFS_VID_LO:   byte_sel = vid_in[7:0];
			`HDRL_OFS_VID_HI:   byte_sel = vid_in[15:8];
			`HDRL_OFS_PID_LO:   byte_sel = pid_in[7:0];
			`HDRL_OFS_PID_HI:   byte_sel = pid_in[15:8];
			`HDRL_OFS_DID_LO:   byte_sel = did_in[7:0];
			`HDRL_OFS_DID_HI:   byte_sel = did_in[15:8];
			`HDRL_OFS_MFG_IDX:  byte_sel = string_en_in ? `HDRL_STR_MFG  : `HDRL_STR_NONE;
			`HDRL_OFS_PROD_IDX: byte_sel = string_en_in ? `HDRL_STR_PROD : `HDRL_STR_NONE;
			`HDRL_OFS_SER_IDX:  byte_sel = string_en_in ? `HDRL_STR_SER  : `HDRL_STR_NONE;
			`HDRL_OFS_NUM_CFG:  byte_sel = `HDRL_DESC_NUM_CFG;
			default:            byte_sel = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_data_out <= 8'h00;
		end else if (rd_en_in) begin
			rd_data_out <= byte_sel;
		end
	end

endmodule : hdrl_desc_rom

// ==== logic/hdrl_hub_enum.sv ====
// upstream enumeration logic: attach gating, bus-reset actions, descriptor
//
// Functional notes
// - no attach until all descriptor fields loaded
// - upstream bus reset never forwarded downstream
// - bus reset returns device address to zero
// - bus reset returns hub to unconfigured
// - bus reset clears downstream port power enables
// - bus reset empties all translator buffers
// - bus reset wakes a suspended hub
// - high-speed disabled: attach full-speed, full-speed descriptor
// - length 12h, type 01h, one configuration
// - release 0200h, control max packet 40h
// - class 09h, subclass and protocol 00h
// - vendor, product, device ids from defaults or load
// - string indexes 00 or 01/02/03 per string enable
`timescale 1ns/1ns
`include "hdrl_params.svh"

module hdrl_hub_enum
	import hdrl_pkg::*;
#(
	parameter logic [15:0] DEF_VID   = `HDRL_ID_DEFAULT,
	parameter logic [15:0] DEF_PID   = `HDRL_ID_DEFAULT,
	parameter logic [15:0] DEF_DID   = `HDRL_ID_DEFAULT,
	parameter int          NUM_PORTS = 3
)(
	input  wire logic                 sys_clk_in,
	input  wire logic                 rstn_in,
	input  wire logic                 use_rom_defaults_in,
	input  hdrl_id_load_t             id_load_in,
	input  wire logic                 load_done_in,
	input  wire logic                 string_en_in,
	input  wire logic                 hs_disable_in,
	input  wire logic                 bus_reset_in,
	input  wire logic                 suspend_req_in,
	input  wire logic                 resume_in,
	input  wire logic                 set_address_in,
	input  wire logic [6:0]           new_address_in,
	input  wire logic                 set_config_in,
	input  wire logic [7:0]           new_config_in,
	input  wire logic                 port_power_set_in,
	input  wire logic [NUM_PORTS:1]   port_power_value_in,
	input  hdrl_desc_req_t            desc_req_in,
	output logic                      attach_out,
	output logic                      full_speed_only_out,
	output logic                      suspended_out,
	output logic [6:0]                dev_address_out,
	output logic [7:0]                config_value_out,
	output logic [NUM_PORTS:1]        port_power_control_out,
	output logic                      tt_flush_out,
	output logic                      downstream_reset_out,
	output hdrl_desc_rsp_t            desc_rsp_out
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// the bus reset and suspend levels come from the line state detector
	// on this clock; the enable straps are pins and need two flops
	logic [1:0] hs_dis_sync_reg;
	logic [1:0] str_en_sync_reg;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hs_dis_sync_reg <= 2'b00;
			str_en_sync_reg <= 2'b00;
		end else begin
			hs_dis_sync_reg <= {hs_dis_sync_reg[0], hs_disable_in};
			str_en_sync_reg <= {str_en_sync_reg[0], string_en_in};
		end
	end

	logic hs_dis;
	logic str_en;
	assign hs_dis = hs_dis_sync_reg[1];
	assign str_en = str_en_sync_reg[1];

	// ------------------------------------------------------------
	// strap settling
	// ------------------------------------------------------------
	// straps are trusted only once both stages hold pin values;
	// attaching sooner would latch the reset value as the speed mode
	logic [1:0] strap_fill_reg;
	logic       straps_ok;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			strap_fill_reg <= 2'b00;
		end else begin
			strap_fill_reg <= {strap_fill_reg[0], 1'b1};
		end
	end

	assign straps_ok = strap_fill_reg[1];

	// ------------------------------------------------------------
	// bus reset edge
	// ------------------------------------------------------------
	logic bus_reset_d_reg;
	logic bus_reset_rise;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus_reset_d_reg <= 1'b0;
		end else begin
			bus_reset_d_reg <= bus_reset_in;
		end
	end

	assign bus_reset_rise = bus_reset_in & ~bus_reset_d_reg;

	// ------------------------------------------------------------
	// descriptor field load
	// ------------------------------------------------------------
	logic [15:0] vid_reg;
	logic [15:0] pid_reg;
	logic [15:0] did_reg;
	logic [2:0]  fld_valid_reg;
	logic        all_loaded;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vid_reg       <= `HDRL_ID_DEFAULT;
			pid_reg       <= `HDRL_ID_DEFAULT;
			did_reg       <= `HDRL_ID_DEFAULT;
			fld_valid_reg <= 3'h0;
		end else if (fld_valid_reg != `HDRL_FLD_ALL || !load_done_in) begin
			// fields are frozen once all are loaded and load_done_in is high, so enumeration stays stable
			if (use_rom_defaults_in) begin
				vid_reg       <= DEF_VID;
				pid_reg       <= DEF_PID;
				did_reg       <= DEF_DID;
				fld_valid_reg <= `HDRL_FLD_ALL;
			end else if (id_load_in.valid) begin
				unique case (id_load_in.sel)
					2'b00: begin
						vid_reg          <= id_load_in.value;
						fld_valid_reg[0] <= 1'b1;
					end
					2'b01: begin
						pid_reg          <= id_load_in.value;
						fld_valid_reg[1] <= 1'b1;
					end
					2'b10: begin
						did_reg          <= id_load_in.value;
						fld_valid_reg[2] <= 1'b1;
					end
					// select code 3 names no field and is dropped
					default: begin
						fld_valid_reg <= fld_valid_reg;
					end
				endcase
			end
		end
	end

	// attach also waits until the straps have settled
	assign all_loaded = (fld_valid_reg == `HDRL_FLD_ALL) && load_done_in && straps_ok;

	// ------------------------------------------------------------
	// attach and power state
	// ------------------------------------------------------------
	hdrl_state_t state_reg;
	hdrl_state_t state_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			HDRL_ST_LOADING: begin
				if (all_loaded) begin
					state_next = HDRL_ST_ATTACHED;
				end
			end
			HDRL_ST_ATTACHED: begin
				// a reset in the same cycle keeps the hub awake
				if (suspend_req_in && !bus_reset_in) begin
					state_next = HDRL_ST_SUSPENDED;
				end
			end
			HDRL_ST_SUSPENDED: begin
				if (bus_reset_in || resume_in) begin
					state_next = HDRL_ST_ATTACHED;
				end
			end
			default: begin
				state_next = HDRL_ST_LOADING;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= HDRL_ST_LOADING;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			attach_out          <= 1'b0;
			full_speed_only_out <= 1'b0;
			suspended_out       <= 1'b0;
		end else begin
			attach_out    <= (state_next != HDRL_ST_LOADING);
			suspended_out <= (state_next == HDRL_ST_SUSPENDED);
			// speed mode latched while detached, held for the attachment
			if (state_reg == HDRL_ST_LOADING) begin
				full_speed_only_out <= hs_dis;
			end
		end
	end

	// ------------------------------------------------------------
	// hub-level state and bus reset actions
	// ------------------------------------------------------------
	// a bus reset outranks a set request landing in the same cycle
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dev_address_out <= `HDRL_ADDR_DEFAULT;
		end else if (bus_reset_in) begin
			dev_address_out <= `HDRL_ADDR_DEFAULT;
		end else if (set_address_in) begin
			dev_address_out <= new_address_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			config_value_out <= `HDRL_CFG_NONE;
		end else if (bus_reset_in) begin
			config_value_out <= `HDRL_CFG_NONE;
		end else if (set_config_in) begin
			config_value_out <= new_config_in;
		end
	end

	localparam logic [NUM_PORTS:1] PWR_OFF = NUM_PORTS'(`HDRL_PWR_OFF);

	// one power enable per downstream port
	for (genvar p = 1; p <= NUM_PORTS; p++) begin : g_port_pwr
		always_ff @(posedge sys_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				port_power_control_out[p] <= PWR_OFF[p];
			end else if (bus_reset_in) begin
				port_power_control_out[p] <= PWR_OFF[p];
			end else if (port_power_set_in) begin
				port_power_control_out[p] <= port_power_value_in[p];
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tt_flush_out         <= 1'b0;
			downstream_reset_out <= 1'b0;
		end else begin
			tt_flush_out         <= bus_reset_rise;
			// the upstream reset is absorbed here, never passed on
			downstream_reset_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// full-speed device descriptor readout
	// ------------------------------------------------------------
	logic [7:0] rom_data;
	logic       rsp_pend_reg;
	logic       rsp_last_reg;

	hdrl_desc_rom u_rom (
		.sys_clk_in   (sys_clk_in),
		.rstn_in      (rstn_in),
		.rd_en_in     (desc_req_in.valid),
		.rd_ofs_in    (desc_req_in.offset),
		.string_en_in (str_en),
		.vid_in       (vid_reg),
		.pid_in       (pid_reg),
		.did_in       (did_reg),
		.rd_data_out  (rom_data)
	);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rsp_pend_reg <= 1'b0;
			rsp_last_reg <= 1'b0;
		end else begin
			rsp_pend_reg <= desc_req_in.valid;
			rsp_last_reg <= (desc_req_in.offset == `HDRL_OFS_NUM_CFG);
		end
	end

	// answer one cycle after request, the registered byte
	always_comb begin
		desc_rsp_out.valid = rsp_pend_reg;
		desc_rsp_out.data  = rom_data;
		desc_rsp_out.last  = rsp_pend_reg & rsp_last_reg;
	end

endmodule : hdrl_hub_enum

// ==== test/hdrl_hub_enum_checker.sv ====
// assertions on bus-reset, attach and descriptor timing
`timescale 1ns/1ns
module hdrl_hub_enum_checker
	import hdrl_pkg::*;
#(
	parameter int NUM_PORTS = 3
)(
	input wire logic           sys_clk_in,
	input wire logic           rstn_in,
	input wire logic           load_done_in,
	input wire logic           bus_reset_in,
	input hdrl_desc_req_t      desc_req_in,
	input wire logic           attach_out,
	input wire logic           full_speed_only_out,
	input wire logic           suspended_out,
	input wire logic [6:0]     dev_address_out,
	input wire logic [7:0]     config_value_out,
	input wire logic [NUM_PORTS:1] port_power_control_out,
	input wire logic           tt_flush_out,
	input wire logic           downstream_reset_out,
	input hdrl_desc_rsp_t      desc_rsp_out
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_rst_rise;
		!bus_reset_in ##1 bus_reset_in;
	endsequence
	sequence s_flush_pulse;
		tt_flush_out ##1 !tt_flush_out;
	endsequence
	a_no_fwd_reset: assert property (!downstream_reset_out)
		else $error("bus reset forwarded downstream");
	a_rst_addr_zero: assert property (bus_reset_in |=> dev_address_out == 7'h00)
		else $error("address kept through bus reset");
	a_rst_unconfig: assert property (bus_reset_in |=> config_value_out == 8'h00)
		else $error("configuration kept through bus reset");
	a_rst_power_off: assert property (bus_reset_in |=> port_power_control_out == '0)
		else $error("port power kept through bus reset");
	a_rst_flush: assert property (s_rst_rise |=> s_flush_pulse)
		else $error("translator flush not a single pulse");
	a_rst_wake: assert property (bus_reset_in |=> !suspended_out)
		else $error("still suspended in bus reset");
	a_attach_gate: assert property ($rose(attach_out) |-> $past(load_done_in))
		else $error("attach before load finished");
	a_fs_held: assert property (attach_out && $past(attach_out) |-> $stable(full_speed_only_out))
		else $error("speed mode changed while attached");
	a_desc_answer: assert property (desc_req_in.valid |=> desc_rsp_out.valid)
		else $error("descriptor read not answered");
	a_desc_quiet: assert property (!desc_req_in.valid |=> !desc_rsp_out.valid)
		else $error("descriptor answer without request");
	a_desc_last: assert property (desc_rsp_out.last |-> $past(desc_req_in.offset) == 5'h11)
		else $error("last flag on wrong offset");
endmodule : hdrl_hub_enum_checker

bind hdrl_hub_enum hdrl_hub_enum_checker #(.NUM_PORTS(NUM_PORTS)) chk_u (
	.sys_clk_in, .rstn_in, .load_done_in, .bus_reset_in, .desc_req_in, .attach_out,
	.full_speed_only_out, .suspended_out, .dev_address_out, .config_value_out,
	.port_power_control_out, .tt_flush_out, .downstream_reset_out, .desc_rsp_out);

// ==== test/hdrl_host_model.sv ====
// upstream host model issuing descriptor byte reads
`timescale 1ns/1ns
module hdrl_host_model
	import hdrl_pkg::*;
(
	input  wire logic     sys_clk_in,
	input  hdrl_desc_rsp_t desc_rsp_in,
	output hdrl_desc_req_t desc_req_out
);
	initial desc_req_out = '0;
	// offset scrambled once released so a stale offset never looks valid
	task automatic read_byte(input logic [4:0] ofs, output hdrl_desc_rsp_t rsp);
		@(negedge sys_clk_in);
		desc_req_out = {1'b1, ofs};
		@(negedge sys_clk_in);
		desc_req_out = {1'b0, ~ofs};
		rsp = desc_rsp_in;
	endtask : read_byte
endmodule : hdrl_host_model

// ==== test/tb_hub_descriptor_reset_logic.sv ====
// self-checking bench of the hub enumeration logic
`timescale 1ns/1ns
module tb_hub_descriptor_reset_logic
	import hdrl_pkg::*;
;
	// arbitrary neutral id values
	localparam logic [47:0] DEF_IDS = 48'h0246_7e81_5a3c;
	localparam logic [47:0] LD_IDS  = 48'h0305_9a17_4d2c;
	logic           sys_clk_in, rstn_in, use_rom_defaults_in, load_done_in, string_en_in;
	logic           hs_disable_in, bus_reset_in, suspend_req_in, resume_in;
	logic           set_address_in, set_config_in, port_power_set_in;
	logic [6:0]     new_address_in, dev_address_out;
	logic [7:0]     new_config_in, config_value_out;
	logic [3:1]     port_power_value_in, port_power_control_out;
	logic           attach_out, full_speed_only_out, suspended_out;
	logic           tt_flush_out, downstream_reset_out;
	hdrl_id_load_t  id_load_in;
	hdrl_desc_req_t desc_req_in;
	hdrl_desc_rsp_t desc_rsp_out, rsp;
	int             n_mismatch = 0;
	int             compares = 0;
	int             cyc = 0;

	hdrl_hub_enum #(.DEF_VID(DEF_IDS[15:0]), .DEF_PID(DEF_IDS[31:16]), .DEF_DID(DEF_IDS[47:32]),
		.NUM_PORTS(3)) dut_u (
		.sys_clk_in, .rstn_in, .use_rom_defaults_in, .id_load_in, .load_done_in,
		.string_en_in, .hs_disable_in, .bus_reset_in, .suspend_req_in, .resume_in,
		.set_address_in, .new_address_in, .set_config_in, .new_config_in,
		.port_power_set_in, .port_power_value_in, .desc_req_in, .attach_out,
		.full_speed_only_out, .suspended_out, .dev_address_out, .config_value_out,
		.port_power_control_out, .tt_flush_out, .downstream_reset_out, .desc_rsp_out);
	hdrl_host_model host_u (.sys_clk_in, .desc_rsp_in(desc_rsp_out), .desc_req_out(desc_req_in));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic report_and_stop();
		$display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic rd(input logic [4:0] ofs, input logic [7:0] exp);
		host_u.read_byte(ofs, rsp);
		cmp("rsp valid", 16'h0001, 16'(rsp.valid));
		cmp("rsp data", 16'(exp), 16'(rsp.data));
	endtask : rd
	task automatic load_id(input logic [1:0] sel, input logic [15:0] v);
		id_load_in = '{1'b1, sel, v};
		@(negedge sys_clk_in);
		id_load_in = '0;
		@(negedge sys_clk_in);
	endtask : load_id
	task automatic do_reset();
		rstn_in = 1'b0;
		repeat (12) @(negedge sys_clk_in);
		rstn_in = 1'b1;
		repeat (3) @(negedge sys_clk_in);
	endtask : do_reset
	task automatic wait_attach();
		for (int i = 0; i < 40 && attach_out !== 1'b1; i++) @(negedge sys_clk_in);
	endtask : wait_attach
	task automatic set_all(input logic v);
		{set_address_in, set_config_in, port_power_set_in} = {3{v}};
		@(negedge sys_clk_in);
		{set_address_in, set_config_in, port_power_set_in} = 3'h0;
	endtask : set_all

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_attach_gate();
		load_id(2'h0, LD_IDS[15:0]);
		load_id(2'h1, LD_IDS[31:16]);
		load_done_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		cmp("attach early", 16'h0000, 16'(attach_out));
		load_id(2'h2, LD_IDS[47:32]);
		wait_attach();
		cmp("attach", 16'h0001, 16'(attach_out));
		cmp("full speed", 16'h0001, 16'(full_speed_only_out));
		$display("test attach_gate done");
	endtask : t_attach_gate
	task automatic t_desc_table();
		logic [143:0] exp;
		exp = {8'h01, 8'h03, 8'h02, 8'h01, LD_IDS, 64'h4000_0009_0200_0112};
		for (int i = 0; i < 18; i++) rd(5'(i), exp[8*i +: 8]);
		cmp("last flag", 16'h0001, 16'(rsp.last));
		rd(5'h12, 8'h00);
		string_en_in = 1'b0;
		repeat (4) @(negedge sys_clk_in);
		for (int i = 14; i < 17; i++) rd(5'(i), 8'h00);
		string_en_in = 1'b1;
		$display("test desc_table done");
	endtask : t_desc_table
	task automatic t_bus_reset();
		new_address_in = 7'h2a;
		new_config_in = 8'h01;
		port_power_value_in = 3'h7;
		set_all(1'b1);
		suspend_req_in = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		suspend_req_in = 1'b0;
		cmp("address set", 16'h002a, 16'(dev_address_out));
		cmp("config set", 16'h0001, 16'(config_value_out));
		cmp("power set", 16'h0007, 16'(port_power_control_out));
		cmp("suspended", 16'h0001, 16'(suspended_out));
		bus_reset_in = 1'b1;
		new_address_in = 7'h15;
		set_all(1'b1);
		cmp("flush", 16'h0001, 16'(tt_flush_out));
		cmp("address", 16'h0000, 16'(dev_address_out));
		cmp("config", 16'h0000, 16'(config_value_out));
		cmp("power", 16'h0000, 16'(port_power_control_out));
		cmp("awake", 16'h0000, 16'(suspended_out));
		cmp("no forward", 16'h0000, 16'(downstream_reset_out));
		@(negedge sys_clk_in);
		cmp("flush end", 16'h0000, 16'(tt_flush_out));
		cmp("address held", 16'h0000, 16'(dev_address_out));
		bus_reset_in = 1'b0;
		suspend_req_in = 1'b1;
		@(negedge sys_clk_in);
		suspend_req_in = 1'b0;
		cmp("suspend again", 16'h0001, 16'(suspended_out));
		resume_in = 1'b1;
		@(negedge sys_clk_in);
		resume_in = 1'b0;
		cmp("resumed", 16'h0000, 16'(suspended_out));
		$display("test bus_reset done");
	endtask : t_bus_reset
	task automatic t_rom_defaults();
		use_rom_defaults_in = 1'b1;
		do_reset();
		wait_attach();
		cmp("rom attach", 16'h0001, 16'(attach_out));
		cmp("rom full speed", 16'h0001, 16'(full_speed_only_out));
		for (int i = 0; i < 6; i++) rd(5'(8 + i), DEF_IDS[8*i +: 8]);
		hs_disable_in = 1'b0;
		do_reset();
		wait_attach();
		cmp("hs attach", 16'h0001, 16'(attach_out));
		cmp("hs mode", 16'h0000, 16'(full_speed_only_out));
		$display("test rom_defaults done");
	endtask : t_rom_defaults

	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		{use_rom_defaults_in, load_done_in, bus_reset_in, suspend_req_in, resume_in} = 5'h00;
		{set_address_in, set_config_in, port_power_set_in} = 3'h0;
		{string_en_in, hs_disable_in} = 2'h3;
		new_address_in = 7'h00;
		new_config_in = 8'h00;
		port_power_value_in = 3'h0;
		id_load_in = '0;
		do_reset();
		t_attach_gate();
		t_desc_table();
		t_bus_reset();
		t_rom_defaults();
		report_and_stop();
	end
endmodule : tb_hub_descriptor_reset_logic
